// File: design/ivr_core.sv
// nested vectored interrupt controller with routed peripheral sources
`timescale 1ns/100ps
`default_nettype none
// Summary of operation
// - 16 system exceptions, IRQ n is exception n+16
// - offset 0 stack pointer, offset 4 reset
// - bus error raises bus fault at 0x14
// - usage fault 0x18, memory fault 0x10
// - supervisor call is 11; reserved never raised
// - IRQ vectors at 0x40 to 0xBC
// - NMI routed from any pin or disconnected
// - three to eight levels set, four or eight implemented, changeable live
// - priority splits into group and subpriority
// - tail-chain and late arrival supported
// - hardware saves and restores state
// - equal priority, lower vector wins
// - each vector picks one of three sources
// - DMA lines split low and high groups
// - logic source n is logic line n
// - any source reachable through logic path
// - fixed assignments, slots 2 26 27 reserved
module ivr_core
    import ivr_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // interrupt sources
    input wire logic [31:0] fixed_irq,
    input wire logic [15:0] dma_term_lines_low,
    input wire logic [15:0] dma_term_lines_high,
    input wire logic [31:0] logic_irq,
    // nmi routing
    input wire logic [63:0] pin_levels,
    input wire logic nmi_route_en,
    input wire logic [5:0] nmi_pin_sel,
    // fault and call events from the core
    input wire logic bus_err_fetch,
    input wire logic bus_err_data,
    input wire logic mem_fault,
    input wire logic undef_instr,
    input wire logic state_switch,
    input wire logic svc_exec,
    input wire logic debug_req,
    input wire logic defer_req,
    input wire logic tick_req,
    // configuration
    input wire logic [63:0] src_sel,
    input wire logic [31:0] irq_enable,
    input wire logic [95:0] irq_prio,
    input wire logic [23:0] sys_prio,
    input wire logic [2:0] fault_enable,
    input wire logic [3:0] prio_levels,
    input wire logic [2:0] prio_group,
    // core handshake
    input wire logic entry_ack,
    input wire logic exit_req,
    output logic exc_req,
    output logic [5:0] exc_num,
    output logic [9:0] exc_ofs,
    output logic [5:0] active_num_q,
    output logic save_state,
    output logic restore_state,
    output logic tail_chain,
    output logic [9:0] reset_ofs,
    output logic [9:0] stack_ofs
);
    typedef enum logic [1:0] {IVR_ST_RUN, IVR_ST_HANDLER} ivr_state_t;
    ivr_state_t state_q;
    logic [31:0] irq_req;
    logic [31:0] irq_pend_q;
    logic [15:0] sys_pend_q;
    logic [5:0] best_num;
    logic [3:0] best_key;
    logic best_valid;
    logic [3:0] active_key_q;
    logic nmi_line;
    logic escalate;
    logic [5:0] exc_num_q;
    logic [9:0] exc_ofs_q;

    // masks a priority down to implemented levels, clamped to 3..8
    function automatic logic [2:0] ivr_mask_prio(input logic [2:0] p, input logic [3:0] lv);
        logic [3:0] l;
        logic [2:0] m;
        l = lv;
        if (l < 4'(IVR_MIN_LEVELS)) begin
            l = 4'(IVR_MIN_LEVELS);
        end
        if (l > 4'(IVR_MAX_LEVELS)) begin
            l = 4'(IVR_MAX_LEVELS);
        end
        m = 3'h7;
        if (l <= 4'h4) begin
            m = 3'h6;
        end
        if (l <= 4'h2) begin
            m = 3'h4;
        end
        return p & m;
    endfunction

    // preempting group part of a priority
    function automatic logic [2:0] ivr_group(input logic [2:0] p, input logic [2:0] g);
        logic [2:0] m;
        m = 3'(3'h7 << g);
        return p & m;
    endfunction

    // programmable priority of a system exception; slot 7 spare
    function automatic logic [2:0] ivr_sys_prio(input logic [23:0] all, input logic [5:0] s);
        int slot;
        slot = 7;
        unique case (s)
            IVR_EXC_MEM: slot = 0;
            IVR_EXC_BUS: slot = 1;
            IVR_EXC_USAGE: slot = 2;
            IVR_EXC_SVCALL: slot = 3;
            IVR_EXC_DEBUG: slot = 4;
            IVR_EXC_DEFER: slot = 5;
            IVR_EXC_TICK: slot = 6;
            default: slot = 7;
        endcase
        return all[3*slot +: 3];
    endfunction

    // vector table offset of an exception number
    function automatic logic [9:0] ivr_offset(input logic [5:0] n);
        return {2'h0, n, 2'h0};
    endfunction

    // source routing for the 32 peripheral vectors
    ivr_src_mux u_mux (
        .fixed_irq(fixed_irq),
        .dma_term_lines_low(dma_term_lines_low),
        .dma_term_lines_high(dma_term_lines_high),
        .logic_irq(logic_irq),
        .src_sel(src_sel),
        .irq_req(irq_req)
    );

    // nmi from any pin or none
    assign nmi_line = nmi_route_en & pin_levels[nmi_pin_sel];
    assign stack_ofs = IVR_OFS_STACK;
    assign reset_ofs = IVR_OFS_RESET;

    // a fault with its handler disabled escalates
    assign escalate = ((bus_err_fetch | bus_err_data) & ~fault_enable[1])
        | (mem_fault & ~fault_enable[0])
        | ((undef_instr | state_switch) & ~fault_enable[2]);

    // peripheral pending bits, set wins over clear on entry
    always_ff @(posedge clk) begin
        if (rst) begin
            irq_pend_q <= IVR_RST_VEC;
        end else begin
            for (int n = 0; n < 32; n++) begin
                if (irq_req[n]) begin
                    irq_pend_q[n] <= 1'b1;
                end else if (entry_ack && exc_num_q == 6'(n + 16)) begin
                    irq_pend_q[n] <= 1'b0;
                end
            end
        end
    end

    // system exception pending bits; reserved slots stay zero
    always_ff @(posedge clk) begin
        if (rst) begin
            sys_pend_q <= 16'h0000;
        end else begin
            for (int s = 0; s < 16; s++) begin
                logic set;
                set = 1'b0;
                unique case (6'(s))
                    IVR_EXC_NMI: set = nmi_line;
                    IVR_EXC_HARD: set = escalate;
                    IVR_EXC_MEM: set = mem_fault & fault_enable[0];
                    IVR_EXC_BUS: set = (bus_err_fetch | bus_err_data) & fault_enable[1];
                    IVR_EXC_USAGE: set = (undef_instr | state_switch) & fault_enable[2];
                    IVR_EXC_SVCALL: set = svc_exec;
                    IVR_EXC_DEBUG: set = debug_req;
                    IVR_EXC_DEFER: set = defer_req;
                    IVR_EXC_TICK: set = tick_req;
                    default: set = 1'b0;
                endcase
                if (set) begin
                    sys_pend_q[s] <= 1'b1;
                end else if (entry_ack && exc_num_q == 6'(s)) begin
                    sys_pend_q[s] <= 1'b0;
                end
            end
        end
    end

    // arbitration: key 1..2 fixed, 3+prio programmable, first lowest wins
    always_comb begin
        logic [3:0] k;
        logic [2:0] p;
        k = 4'h0;
        p = 3'h0;
        best_valid = 1'b0;
        best_num = IVR_EXC_NONE;
        best_key = 4'hF;
        for (int s = 2; s < 16; s++) begin
            if (sys_pend_q[s]) begin
                if (s == 2) begin
                    k = 4'h1;
                end else if (s == 3) begin
                    k = 4'h2;
                end else begin
                    p = ivr_mask_prio(ivr_sys_prio(sys_prio, 6'(s)), prio_levels);
                    k = 4'h3 + {1'b0, p};
                end
                if (k < best_key) begin
                    best_key = k;
                    best_num = 6'(s);
                    best_valid = 1'b1;
                end
            end
        end
        for (int n = 0; n < 32; n++) begin
            if (irq_pend_q[n] && irq_enable[n]) begin
                p = ivr_mask_prio(irq_prio[3*n +: 3], prio_levels);
                k = 4'h3 + {1'b0, p};
                if (k < best_key) begin
                    best_key = k;
                    best_num = 6'(n + 16);
                    best_valid = 1'b1;
                end
            end
        end
    end

    // preemption compares group parts; fixed keys compare whole
    logic preempt;
    always_comb begin
        if (state_q == IVR_ST_RUN) begin
            preempt = best_valid;
        end else if (best_key < 4'h3 || active_key_q < 4'h3) begin
            preempt = best_valid && best_key < active_key_q;
        end else begin
            preempt = best_valid && ivr_group(3'(best_key - 4'h3), prio_group)
                < ivr_group(3'(active_key_q - 4'h3), prio_group);
        end
    end

    // candidate latched; late arrival replaces it until accepted
    always_ff @(posedge clk) begin
        if (rst) begin
            exc_num_q <= IVR_EXC_NONE;
            exc_ofs_q <= IVR_OFS_STACK;
        end else begin
            exc_num_q <= preempt ? best_num : IVR_EXC_NONE;
            exc_ofs_q <= preempt ? ivr_offset(best_num) : IVR_OFS_STACK;
        end
    end
    assign exc_req = exc_num_q != IVR_EXC_NONE && preempt;
    assign exc_num = exc_num_q;
    assign exc_ofs = exc_ofs_q;

    // active handler tracking, single level kept
    always_ff @(posedge clk) begin
        if (rst) begin
            state_q <= IVR_ST_RUN;
            active_num_q <= IVR_EXC_NONE;
            active_key_q <= 4'hF;
        end else if (exc_req && entry_ack) begin
            state_q <= IVR_ST_HANDLER;
            active_num_q <= exc_num_q;
            active_key_q <= best_key;
        end else if (exit_req && state_q == IVR_ST_HANDLER) begin
            state_q <= IVR_ST_RUN;
            active_num_q <= IVR_EXC_NONE;
            active_key_q <= 4'hF;
        end
    end

    // automatic stacking on entry from IVR_ST_RUN; restore skipped on tail-chain
    assign save_state = exc_req && entry_ack && state_q == IVR_ST_RUN;
    assign tail_chain = exit_req && state_q == IVR_ST_HANDLER && best_valid;
    assign restore_state = exit_req && state_q == IVR_ST_HANDLER && !best_valid;
endmodule
`default_nettype wire

// File: design/ivr_pkg.sv
// package of constants and types for the interrupt vector routing block
package ivr_pkg;
    localparam int unsigned IVR_NUM_SYS = 16;
    localparam int unsigned IVR_NUM_IRQ = 32;
    localparam int unsigned IVR_EXC_W = 6;
    localparam int unsigned IVR_PRIO_W = 3;
    localparam int unsigned IVR_MIN_LEVELS = 3;
    localparam int unsigned IVR_MAX_LEVELS = 8;
    localparam int unsigned IVR_IRQ_W = 5;
    localparam int unsigned IVR_HALF_IRQ = 16;
    // exception numbers
    localparam logic [5:0] IVR_EXC_NONE = 6'h00;
    localparam logic [5:0] IVR_EXC_RESET = 6'h01;
    localparam logic [5:0] IVR_EXC_NMI = 6'h02;
    localparam logic [5:0] IVR_EXC_HARD = 6'h03;
    localparam logic [5:0] IVR_EXC_MEM = 6'h04;
    localparam logic [5:0] IVR_EXC_BUS = 6'h05;
    localparam logic [5:0] IVR_EXC_USAGE = 6'h06;
    localparam logic [5:0] IVR_EXC_SVCALL = 6'h0B;
    localparam logic [5:0] IVR_EXC_DEBUG = 6'h0C;
    localparam logic [5:0] IVR_EXC_DEFER = 6'h0E;
    localparam logic [5:0] IVR_EXC_TICK = 6'h0F;
    localparam logic [5:0] IVR_EXC_IRQ0 = 6'h10;
    // vector table offsets
    localparam logic [9:0] IVR_OFS_STACK = 10'h000;
    localparam logic [9:0] IVR_OFS_RESET = 10'h004;
    localparam logic [9:0] IVR_OFS_MEM = 10'h010;
    localparam logic [9:0] IVR_OFS_BUS = 10'h014;
    localparam logic [9:0] IVR_OFS_USAGE = 10'h018;
    localparam logic [9:0] IVR_OFS_SVCALL = 10'h02C;
    localparam logic [9:0] IVR_OFS_IRQ_FIRST = 10'h040;
    localparam logic [9:0] IVR_OFS_IRQ_LAST = 10'h3FC;
    // fixed-function slots that carry no source
    localparam logic [31:0] IVR_FIXED_RSVD = 32'h0C00_0004;
    // reset values
    localparam logic [2:0] IVR_RST_PRIO = 3'h0;
    localparam logic [3:0] IVR_RST_LEVELS = 4'h8;
    localparam logic [2:0] IVR_RST_GROUP = 3'h0;
    localparam logic [31:0] IVR_RST_VEC = 32'h0000_0000;
    // per-vector source selection
    typedef enum logic [1:0] {
        IVR_SRC_FIXED,
        IVR_SRC_DMA,
        IVR_SRC_LOGIC,
        IVR_SRC_NONE
    } ivr_src_t;
endpackage

// File: design/ivr_src_mux.sv
// source selection for the peripheral interrupt vectors
`timescale 1ns/100ps
`default_nettype none
module ivr_src_mux
    import ivr_pkg::*;
(
    // source groups
    input wire logic [31:0] fixed_irq,
    input wire logic [15:0] dma_term_lines_low,
    input wire logic [15:0] dma_term_lines_high,
    input wire logic [31:0] logic_irq,
    // selection, two bits per vector
    input wire logic [63:0] src_sel,
    // routed requests
    output logic [31:0] irq_req
);
    logic [31:0] fixed_clean;
    logic [31:0] dma_all;

    // reserved fixed slots are forced low
    assign fixed_clean = fixed_irq & ~IVR_FIXED_RSVD;
    // vectors 0-15 take low group, 16-31 the high group
    assign dma_all = {dma_term_lines_high, dma_term_lines_low};

    // one source per vector
    always_comb begin
        irq_req = '0;
        for (int n = 0; n < 32; n++) begin
            unique case (ivr_src_t'(src_sel[2*n +: 2]))
                IVR_SRC_FIXED: irq_req[n] = fixed_clean[n];
                IVR_SRC_DMA: irq_req[n] = dma_all[n];
                IVR_SRC_LOGIC: irq_req[n] = logic_irq[n];
                IVR_SRC_NONE: irq_req[n] = 1'b0;
            endcase
        end
    end
endmodule
`default_nettype wire

// File: testbench/ivr_checker.sv
// assertion checker for the interrupt vector routing core
`timescale 1ns/100ps
`default_nettype none
module ivr_checker
    import ivr_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // configuration
    input wire logic [31:0] irq_enable,
    input wire logic [2:0] fault_enable,
    // core handshake
    input wire logic entry_ack,
    input wire logic exit_req,
    input wire logic exc_req,
    input wire logic [5:0] exc_num,
    input wire logic [9:0] exc_ofs,
    input wire logic [5:0] active_num_q,
    input wire logic save_state,
    input wire logic restore_state,
    input wire logic tail_chain,
    input wire logic [9:0] reset_ofs,
    input wire logic [9:0] stack_ofs
);
    logic [31:0] en_q;
    // enables one cycle back, for requests chosen a cycle late
    always_ff @(posedge clk) begin
        en_q <= irq_enable;
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    a_table_head: assert property (reset_ofs == 10'h004 && stack_ofs == 10'h000)
        else $error("table head offsets wrong");
    a_ofs_map: assert property (exc_req |-> exc_ofs == {2'b00, exc_num, 2'b00})
        else $error("vector offset does not match number");
    a_num_range: assert property (exc_req |-> exc_num != IVR_EXC_NONE && exc_num < 6'h30)
        else $error("exception number out of range");
    a_no_reserved: assert property (exc_req |-> !(exc_num inside {[6'h07:6'h0A], 6'h0D}))
        else $error("reserved exception raised");
    a_bus_gate: assert property (exc_req && exc_num == IVR_EXC_BUS |-> fault_enable[1])
        else $error("disabled bus fault not escalated");
    a_usage_gate: assert property (exc_req && exc_num == IVR_EXC_USAGE |-> fault_enable[2])
        else $error("disabled usage fault not escalated");
    a_irq_gate: assert property (exc_req && exc_num >= IVR_EXC_IRQ0 |->
        irq_enable[exc_num - IVR_EXC_IRQ0] || en_q[exc_num - IVR_EXC_IRQ0])
        else $error("disabled vector requested");
    a_save_entry: assert property (entry_ack && exc_req |-> save_state)
        else $error("no state save on entry");
    a_active_load: assert property (entry_ack && exc_req && active_num_q == IVR_EXC_NONE
        |=> active_num_q == $past(exc_num))
        else $error("active number not loaded");
    a_restore_exit: assert property (exit_req && active_num_q != 6'h00
        |-> restore_state != tail_chain)
        else $error("exit neither restores nor chains");
    a_tail_chain: assert property (exit_req && exc_req && active_num_q != 6'h00
        |-> tail_chain && !restore_state)
        else $error("no tail chain on busy exit");
    c_tail: cover property (exit_req && tail_chain);
    c_hard: cover property (exc_req && exc_num == IVR_EXC_HARD);
    c_nmi: cover property (exc_req && exc_num == IVR_EXC_NMI);
endmodule
bind ivr_core ivr_checker chk_u (.clk, .rst, .irq_enable, .fault_enable, .entry_ack, .exit_req,
    .exc_req, .exc_num, .exc_ofs, .active_num_q, .save_state, .restore_state, .tail_chain,
    .reset_ofs, .stack_ofs);
`default_nettype wire

// File: testbench/ivr_cpu_model.sv
// processor core model answering exception requests
`timescale 1ns/100ps
`default_nettype none
module ivr_cpu_model (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // pacing and request
    input wire logic [3:0] ack_wait,
    input wire logic exc_req,
    // handshake back
    output logic entry_ack,
    output logic exit_req
);
    logic busy_q;
    logic [3:0] cnt_q;
    // ack after ack_wait cycles, leave the handler after six
    always_ff @(posedge clk) begin
        entry_ack <= 1'b0;
        exit_req <= 1'b0;
        cnt_q <= cnt_q + 4'h1;
        if (rst || (!busy_q && !exc_req)) begin
            busy_q <= 1'b0;
            cnt_q <= 4'h0;
        end else if (!busy_q && cnt_q >= ack_wait) begin
            entry_ack <= 1'b1;
            busy_q <= 1'b1;
            cnt_q <= 4'h0;
        end else if (busy_q && cnt_q == 4'h6) begin
            exit_req <= 1'b1;
            busy_q <= 1'b0;
            cnt_q <= 4'h0;
        end
    end
endmodule
`default_nettype wire

// File: testbench/testbench.sv
// self-checking bench for the interrupt vector routing core
`timescale 1ns/100ps
`default_nettype none
module testbench
    import ivr_pkg::*;
;
    logic clk = 1'b0, rst = 1'b1, nmi_route_en = 1'b0, tail_seen = 1'b0;
    logic [31:0] fixed_irq = 32'h0, logic_irq = 32'h0, irq_enable = 32'hFFFF_FFFF;
    logic [15:0] dma_term_lines_low = 16'h0, dma_term_lines_high = 16'h0;
    logic [63:0] pin_levels = 64'h0, src_sel = 64'h0;
    logic [5:0] nmi_pin_sel = 6'h00, exc_num, active_num_q;
    logic [8:0] ev = 9'h000;
    logic [95:0] irq_prio = 96'h0;
    logic [23:0] sys_prio = 24'h0;
    logic [2:0] fault_enable = 3'h7, prio_group = 3'h0;
    logic [3:0] prio_levels = 4'h8, ack_wait = 4'h0;
    logic [9:0] exc_ofs, reset_ofs, stack_ofs;
    logic entry_ack, exit_req, exc_req, save_state, restore_state, tail_chain;
    int err_count = 0;
    int check_count = 0;
    // clock and tail-chain monitor
    always #2 clk = ~clk;
    always @(posedge clk) if (tail_chain === 1'b1) tail_seen <= 1'b1;
    ivr_core dut_u (.clk, .rst, .fixed_irq, .dma_term_lines_low, .dma_term_lines_high,
        .logic_irq, .pin_levels, .nmi_route_en, .nmi_pin_sel, .bus_err_data(ev[0]),
        .bus_err_fetch(ev[1]), .undef_instr(ev[2]), .state_switch(ev[3]), .mem_fault(ev[4]),
        .svc_exec(ev[5]), .debug_req(ev[6]), .defer_req(ev[7]), .tick_req(ev[8]), .src_sel,
        .irq_enable, .irq_prio, .sys_prio, .fault_enable, .prio_levels, .prio_group,
        .entry_ack, .exit_req, .exc_req, .exc_num, .exc_ofs, .active_num_q, .save_state,
        .restore_state, .tail_chain, .reset_ofs, .stack_ofs);
    ivr_cpu_model cpu_u (.clk, .rst, .ack_wait, .exc_req, .entry_ack, .exit_req);
    task automatic chk(input string what, input logic [9:0] exp, input logic [9:0] got);
        check_count++;
        if (got !== exp) begin
            err_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask
    // drop every source line at the next edge
    task automatic clr();
        @(posedge clk);
        fixed_irq <= 32'h0;
        logic_irq <= 32'h0;
        dma_term_lines_low <= 16'h0;
        dma_term_lines_high <= 16'h0;
        pin_levels <= 64'h0;
        ev <= 9'h000;
    endtask
    task automatic expect_exc(input logic [5:0] num);
        int n;
        n = 0;
        while (exc_req !== 1'b1 && n < 40) begin
            @(negedge clk);
            n++;
        end
        chk("exc_num", {4'h0, num}, {4'h0, exc_num});
        chk("exc_ofs", {2'h0, num, 2'h0}, exc_ofs);
        n = 0;
        while (exit_req !== 1'b1 && n < 60) begin
            @(negedge clk);
            n++;
        end
        chk("active_num_q", {4'h0, num}, {4'h0, active_num_q});
        repeat (2) @(negedge clk);
    endtask
    task automatic expect_none();
        repeat (20) begin
            @(negedge clk);
            chk("quiet", 10'h000, {9'h0, exc_req});
        end
    endtask
    task automatic t_sources();
        logic [4:0] v [4] = '{5'd0, 5'd3, 5'd20, 5'd31};
        ivr_src_t k [4] = '{IVR_SRC_FIXED, IVR_SRC_DMA, IVR_SRC_DMA, IVR_SRC_LOGIC};
        for (int i = 0; i < 4; i++) begin
            @(posedge clk);
            src_sel[2*v[i] +: 2] <= k[i];
            fixed_irq[v[i]] <= (k[i] == IVR_SRC_FIXED);
            dma_term_lines_low[v[i][3:0]] <= (k[i] == IVR_SRC_DMA && !v[i][4]);
            dma_term_lines_high[v[i][3:0]] <= (k[i] == IVR_SRC_DMA && v[i][4]);
            logic_irq[v[i]] <= (k[i] == IVR_SRC_LOGIC);
            clr();
            expect_exc({1'b0, v[i]} + IVR_EXC_IRQ0);
        end
    endtask
    task automatic t_equal();
        @(posedge clk);
        ack_wait <= 4'h3;
        fixed_irq <= 32'h0000_0220;
        clr();
        expect_exc(6'd21);
        expect_exc(6'd25);
        chk("tail_seen", 10'h001, {9'h0, tail_seen});
    endtask
    task automatic t_refused();
        @(posedge clk);
        src_sel[13:12] <= IVR_SRC_NONE;
        irq_enable[7] <= 1'b0;
        fixed_irq <= 32'h0C00_00C4;
        pin_levels <= 64'hFFFF_FFFF_FFFF_FFFF;
        expect_none();
        clr();
    endtask
    task automatic t_faults();
        logic [5:0] num [9] = '{6'd5, 6'd3, 6'd6, 6'd3, 6'd4, 6'd11, 6'd12, 6'd14, 6'd15};
        logic [2:0] en [9] = '{3'h2, 3'h0, 3'h4, 3'h0, 3'h1, 3'h7, 3'h7, 3'h7, 3'h7};
        for (int i = 0; i < 9; i++) begin
            @(posedge clk);
            ack_wait <= 4'h0;
            fault_enable <= en[i];
            ev <= 9'h001 << i;
            clr();
            expect_exc(num[i]);
        end
    endtask
    task automatic t_nmi();
        @(posedge clk);
        nmi_route_en <= 1'b1;
        nmi_pin_sel <= 6'h28;
        pin_levels[40] <= 1'b1;
        clr();
        expect_exc(IVR_EXC_NMI);
    endtask
    task automatic stop_test();
        $display("checks %0d mismatches %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    // main sequence
    initial begin
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        @(negedge clk);
        chk("reset_ofs", 10'h004, reset_ofs);
        chk("stack_ofs", 10'h000, stack_ofs);
        t_sources();
        t_equal();
        t_refused();
        t_faults();
        t_nmi();
        stop_test();
    end
    // watchdog
    initial begin
        #100000;
        err_count++;
        stop_test();
    end
endmodule
`default_nettype wire
